// ### hw/drtl_params.svh
// named constants of the dual rs485 test link: timing, crc, layout, map
// assumes a 20 mhz pclk shared by every part of the link logic
`ifndef DRTL_PARAMS_SVH
`define DRTL_PARAMS_SVH

// line timing
`define DRTL_PCLK_HZ        20000000
`define DRTL_BAUD           115200
`define DRTL_BIT_CYCLES     ((`DRTL_PCLK_HZ + `DRTL_BAUD / 2) / `DRTL_BAUD)
`define DRTL_HALF_CYCLES    (`DRTL_BIT_CYCLES / 2)
`define DRTL_GAP_BITS       20
`define DRTL_GAP_CYCLES     (`DRTL_GAP_BITS * `DRTL_BIT_CYCLES)
`define DRTL_ODO_PERIOD_MS  50
`define DRTL_ODO_PERIOD_CYC (`DRTL_PCLK_HZ / 1000 * `DRTL_ODO_PERIOD_MS)

// crc and framing
`define DRTL_CRC_POLY       32'h4a503df1
`define DRTL_CRC_INIT       32'h00ff0000
`define DRTL_CRC_BYTES      4
`define DRTL_CTL_HDR_BYTES  4
`define DRTL_ODO_VAR_BYTES  16
`define DRTL_ODO_SEQ_MOD    255
`define DRTL_FIFO_DEPTH     16

// odometry package fields, msb first
`define DRTL_ODO_DIST       127:96
`define DRTL_ODO_DERR       95:64
`define DRTL_ODO_SPEED      63:48
`define DRTL_ODO_TIME       47:16
`define DRTL_ODO_TERR       15:8
`define DRTL_ODO_SEQ        7:0

// register byte offsets
`define DRTL_REG_CTRL       8'h00
`define DRTL_REG_STATUS     8'h04
`define DRTL_REG_TXDATA     8'h08
`define DRTL_REG_ODO_DIST   8'h0c
`define DRTL_REG_ODO_DERR   8'h10
`define DRTL_REG_ODO_SPEED  8'h14
`define DRTL_REG_ODO_TIME   8'h18
`define DRTL_REG_ODO_MISC   8'h1c
`define DRTL_REG_CTL_INFO   8'h20

// status and control bits
`define DRTL_ST_ODO_CRC     0
`define DRTL_ST_CTL_CRC     1
`define DRTL_ST_FRAME       2
`define DRTL_ST_ODO_NEW     3
`define DRTL_ST_FULL        4
`define DRTL_CTRL_TX_EN     0
`define DRTL_TX_LAST        8

`endif

// ### hw/drtl_pkg.sv
// shared types and the crc step of the dual rs485 test link
// assumes drtl_params.svh is on the include path
`include "drtl_params.svh"

package drtl_pkg;
	typedef logic [7:0]  drtl_byte_t;
	typedef logic [31:0] drtl_word_t;
	typedef logic [8:0]  drtl_txw_t;

	// msb-first crc over one byte, no final inversion
	function automatic drtl_word_t drtl_crc_byte(input drtl_word_t c,
		input drtl_byte_t d);
		drtl_word_t r;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			if (r[31] ^ d[i])
				r = {r[30:0], 1'b0} ^ `DRTL_CRC_POLY;
			else
				r = {r[30:0], 1'b0};
		end
		return r;
	endfunction
endpackage

// ### hw/drtl_link_if.sv
// the three rs485 lines between adapter and test environment
// a line nobody drives reads high, as the bias resistors make it
`timescale 1ns/100ps

interface drtl_link_if;
	logic ctl_down_txd;
	logic ctl_down_de;
	logic ctl_up_txd;
	logic ctl_up_de;
	logic odo_txd;
	logic odo_de;
	logic ctl_down_line;
	logic ctl_up_line;
	logic odo_line;

	// receiver view of each pair
	assign ctl_down_line = ctl_down_de ? ctl_down_txd : 1'b1;
	assign ctl_up_line   = ctl_up_de ? ctl_up_txd : 1'b1;
	assign odo_line      = odo_de ? odo_txd : 1'b1;

	modport device (input ctl_down_line, input odo_line,
		output ctl_up_txd, output ctl_up_de);
	modport host (input ctl_up_line, output ctl_down_txd,
		output ctl_down_de, output odo_txd, output odo_de);
endinterface

// ### hw/drtl_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; ready and valid come from flip-flops
`timescale 1ns/100ps

module drtl_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  logic         pclk,
	input  logic         presetn,
	input  logic         in_valid,
	input  logic [W-1:0] in_data,
	output logic         in_ready,
	output logic         out_valid,
	input  logic         out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   cnt;
	logic [AW:0]   next_cnt;
	logic          push;
	logic          pop;

	// handshakes and next fill level
	assign push = in_valid & in_ready;
	assign pop  = out_valid & out_ready;
	assign next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data = mem[rd_ptr];

	// storage
	always_ff @(posedge pclk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers, level and registered flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			cnt       <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			cnt       <= next_cnt;
			in_ready  <= next_cnt != (AW+1)'(D);
			out_valid <= next_cnt != '0;
		end
	end
endmodule

// ### hw/drtl_device.sv
// adapter end of the link, character and frame engines, apb registers
// assumes pclk at 20 mhz, apb master on one side, drtl_link_if on other
`timescale 1ns/100ps
`include "drtl_params.svh"

module drtl_uart_rx (
	input  logic       pclk,
	input  logic       presetn,
	input  logic       rxd,
	output logic [7:0] rx_byte,
	output logic       rx_stb,
	output logic       rx_ferr,
	output logic       rx_gap
);
	import drtl_pkg::*;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} drtl_rx_t;
	drtl_rx_t    st;
	logic        rxd_prev;
	logic [15:0] cnt;
	logic [15:0] idle_cnt;
	logic [2:0]  nbit;
	logic [7:0]  sh;

	// character receiver, sampled at bit centres
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= RX_IDLE;
			rxd_prev <= 1'b1;
			cnt <= '0;
			nbit <= '0;
			sh <= '0;
			rx_byte <= '0;
			rx_stb <= 1'b0;
			rx_ferr <= 1'b0;
		end
		else
		begin
			rxd_prev <= rxd;
			rx_stb <= 1'b0;
			rx_ferr <= 1'b0;
			if (st != RX_IDLE)
				cnt <= cnt - 16'h0001;
			case (st)
			RX_IDLE:
				if (rxd_prev && !rxd)
				begin
					st <= RX_START;
					cnt <= 16'(`DRTL_HALF_CYCLES - 1);
				end
			RX_START:
				if (cnt == '0)
				begin
					st <= rxd ? RX_IDLE : RX_DATA;
					cnt <= 16'(`DRTL_BIT_CYCLES - 1);
					nbit <= '0;
				end
			RX_DATA:
				if (cnt == '0)
				begin
					sh <= {sh[6:0], rxd};
					nbit <= nbit + 3'h1;
					cnt <= 16'(`DRTL_BIT_CYCLES - 1);
					if (nbit == 3'h7)
						st <= RX_STOP;
				end
			RX_STOP:
				if (cnt == '0)
				begin
					st <= RX_IDLE;
					rx_byte <= sh;
					rx_stb <= rxd;
					rx_ferr <= !rxd;
				end
			default:
				st <= RX_IDLE;
			endcase
		end
	end

	// long idle gap realigns framing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_cnt <= '0;
			rx_gap <= 1'b0;
		end
		else
		begin
			rx_gap <= 1'b0;
			if (!rxd || st != RX_IDLE)
				idle_cnt <= '0;
			else if (idle_cnt != 16'(`DRTL_GAP_CYCLES))
			begin
				idle_cnt <= idle_cnt + 16'h0001;
				rx_gap <= idle_cnt == 16'(`DRTL_GAP_CYCLES - 1);
			end
		end
	end
endmodule

module drtl_uart_tx (
	input  logic       pclk,
	input  logic       presetn,
	input  logic       tx_valid,
	input  logic [7:0] tx_data,
	output logic       tx_ready,
	output logic       txd,
	output logic       de
);
	import drtl_pkg::*;
	logic [9:0]  sh;
	logic [3:0]  nbit;
	logic [15:0] cnt;
	logic        busy;

	assign tx_ready = !busy;
	assign txd = sh[9];

	// start, eight bits msb first, stop; ones when idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sh <= '1;
			nbit <= '0;
			cnt <= '0;
			busy <= 1'b0;
			de <= 1'b0;
		end
		else if (!busy)
		begin
			if (tx_valid)
			begin
				sh <= {1'b0, tx_data, 1'b1};
				nbit <= 4'ha;
				cnt <= 16'(`DRTL_BIT_CYCLES - 1);
				busy <= 1'b1;
				de <= 1'b1;
			end
		end
		else if (cnt != '0)
			cnt <= cnt - 16'h0001;
		else
		begin
			sh <= {sh[8:0], 1'b1};
			cnt <= 16'(`DRTL_BIT_CYCLES - 1);
			nbit <= nbit - 4'h1;
			if (nbit == 4'h1)
			begin
				busy <= 1'b0;
				de <= 1'b0;
			end
		end
	end
endmodule

module drtl_frame_tx (
	input  logic       pclk,
	input  logic       presetn,
	input  logic       in_valid,
	input  logic [7:0] in_data,
	input  logic       in_last,
	output logic       in_ready,
	output logic       txd,
	output logic       de
);
	import drtl_pkg::*;
	typedef enum logic {FT_DATA, FT_CRC} drtl_ft_t;
	drtl_ft_t    st;
	drtl_word_t  crc;
	logic [1:0]  k;
	logic        u_ready;
	logic        u_valid;
	drtl_byte_t  u_data;

	// pass frame bytes, then append the crc msb first
	assign in_ready = (st == FT_DATA) && u_ready;
	assign u_valid = (st == FT_DATA) ? in_valid : 1'b1;
	assign u_data = (st == FT_DATA) ? in_data : crc[31 - 8 * k -: 8];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= FT_DATA;
			crc <= `DRTL_CRC_INIT;
			k <= '0;
		end
		else if (u_valid && u_ready)
		begin
			if (st == FT_DATA)
			begin
				crc <= drtl_crc_byte(crc, in_data);
				if (in_last)
				begin
					st <= FT_CRC;
					k <= '0;
				end
			end
			else
			begin
				k <= k + 2'h1;
				if (k == 2'h3)
				begin
					st <= FT_DATA;
					crc <= `DRTL_CRC_INIT;
				end
			end
		end
	end

	drtl_uart_tx u_tx (
		.pclk     (pclk),
		.presetn  (presetn),
		.tx_valid (u_valid),
		.tx_data  (u_data),
		.tx_ready (u_ready),
		.txd      (txd),
		.de       (de)
	);
endmodule

module drtl_frame_rx #(
	parameter logic [15:0] FIXED_LEN = 16'h0000
) (
	input  logic        pclk,
	input  logic        presetn,
	input  logic        byte_stb,
	input  logic [7:0]  in_byte,
	input  logic        gap,
	output logic        out_stb,
	output logic [7:0]  out_byte,
	output logic [15:0] out_idx,
	output logic        done,
	output logic        crc_ok
);
	import drtl_pkg::*;
	drtl_word_t  crc;
	drtl_word_t  next_crc;
	logic [15:0] idx;
	logic [15:0] len;
	logic [15:0] total;
	logic        last;

	// frame length from fixed size or from the length field
	always_comb
	begin
		next_crc = drtl_crc_byte(crc, in_byte);
		if (FIXED_LEN != '0)
			total = FIXED_LEN + 16'(`DRTL_CRC_BYTES);
		else
			total = len + 16'(`DRTL_CTL_HDR_BYTES + `DRTL_CRC_BYTES);
		last = (FIXED_LEN != '0 || idx >= 16'(`DRTL_CTL_HDR_BYTES))
			&& idx == total - 16'h0001;
	end

	// byte count, crc run over data and received crc, residue zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc <= `DRTL_CRC_INIT;
			idx <= '0;
			len <= '0;
			out_stb <= 1'b0;
			out_byte <= '0;
			out_idx <= '0;
			done <= 1'b0;
			crc_ok <= 1'b0;
		end
		else
		begin
			out_stb <= byte_stb && !gap;
			out_byte <= in_byte;
			out_idx <= idx;
			done <= byte_stb && !gap && last;
			if (gap)
			begin
				idx <= '0;
				crc <= `DRTL_CRC_INIT;
			end
			else if (byte_stb)
			begin
				if (idx == 16'h0002)
					len[15:8] <= in_byte;
				if (idx == 16'h0003)
					len[7:0] <= in_byte;
				if (last)
				begin
					crc_ok <= next_crc == '0;
					idx <= '0;
					crc <= `DRTL_CRC_INIT;
				end
				else
				begin
					idx <= idx + 16'h0001;
					crc <= next_crc;
				end
			end
		end
	end
endmodule

module drtl_device (
	input  logic                  pclk,
	input  logic                  presetn,
	drtl_link_if.device           link,
	input  logic [7:0]            paddr,
	input  logic                  psel,
	input  logic                  penable,
	input  logic                  pwrite,
	input  drtl_pkg::drtl_word_t  pwdata,
	output drtl_pkg::drtl_word_t  prdata,
	output logic                  pready,
	output logic                  pslverr
);
	import drtl_pkg::*;
	logic        acc;
	logic        wr;
	logic        hit;
	drtl_word_t  rd_mux;
	logic        tx_en;
	logic [3:0]  sticky;
	logic [3:0]  st_set;
	logic [3:0]  st_clr;
	logic        f_in_ready;
	logic        f_out_valid;
	drtl_txw_t   f_out;
	logic        ft_ready;
	logic [7:0]  ob;
	logic        os;
	logic        of;
	logic        og;
	logic [7:0]  cb;
	logic        cs;
	logic        cf;
	logic        cg;
	logic        odo_stb;
	logic [7:0]  odo_byte;
	logic [15:0] odo_idx;
	logic        odo_done;
	logic        odo_ok;
	logic        ctl_stb;
	logic [7:0]  ctl_byte;
	logic [15:0] ctl_idx;
	logic        ctl_done;
	logic        ctl_ok;
	logic [127:0] odo_kept;
	logic [7:0]  ctl_hdr;
	logic [7:0]  ctl_seq;
	logic [7:0]  ctl_frames;

	assign acc = psel && penable && pready;
	assign wr  = acc && pwrite;

	// read decode
	always_comb
	begin
		hit = 1'b1;
		rd_mux = '0;
		case (paddr)
		`DRTL_REG_CTRL:      rd_mux[`DRTL_CTRL_TX_EN] = tx_en;
		`DRTL_REG_STATUS:    rd_mux = {27'h0, !f_in_ready, sticky};
		`DRTL_REG_TXDATA:    rd_mux = '0;
		`DRTL_REG_ODO_DIST:  rd_mux = odo_kept[`DRTL_ODO_DIST];
		`DRTL_REG_ODO_DERR:  rd_mux = odo_kept[`DRTL_ODO_DERR];
		`DRTL_REG_ODO_SPEED: rd_mux = {16'h0, odo_kept[`DRTL_ODO_SPEED]};
		`DRTL_REG_ODO_TIME:  rd_mux = odo_kept[`DRTL_ODO_TIME];
		`DRTL_REG_ODO_MISC:
			rd_mux = {16'h0, odo_kept[`DRTL_ODO_TERR], odo_kept[`DRTL_ODO_SEQ]};
		`DRTL_REG_CTL_INFO:  rd_mux = {8'h0, ctl_frames, ctl_hdr, ctl_seq};
		default:             hit = 1'b0;
		endcase
	end

	// apb answer; a txdata write waits while the fifo is full
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else if (psel && penable && !pready)
		begin
			if (!(pwrite && paddr == `DRTL_REG_TXDATA && !f_in_ready))
			begin
				pready <= 1'b1;
				pslverr <= !hit;
				prdata <= pwrite ? '0 : rd_mux;
			end
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// control register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_en <= 1'b1;
		else if (wr && paddr == `DRTL_REG_CTRL)
			tx_en <= pwdata[`DRTL_CTRL_TX_EN];
	end

	// sticky status, write one to clear, set wins
	always_comb
	begin
		st_set = '0;
		st_set[`DRTL_ST_ODO_CRC] = odo_done && !odo_ok;
		st_set[`DRTL_ST_CTL_CRC] = ctl_done && !ctl_ok;
		st_set[`DRTL_ST_FRAME] = of || cf;
		st_set[`DRTL_ST_ODO_NEW] = odo_done && odo_ok;
		st_clr = (wr && paddr == `DRTL_REG_STATUS) ? pwdata[3:0] : 4'h0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sticky <= '0;
		else
			sticky <= (sticky & ~st_clr) | st_set;
	end

	// outgoing control frames: software writes header, seq, length, data
	drtl_fifo #(.W(9), .D(`DRTL_FIFO_DEPTH)) u_txq (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (wr && paddr == `DRTL_REG_TXDATA),
		.in_data   (pwdata[8:0]),
		.in_ready  (f_in_ready),
		.out_valid (f_out_valid),
		.out_ready (ft_ready && tx_en),
		.out_data  (f_out)
	);

	drtl_frame_tx u_ctl_tx (
		.pclk     (pclk),
		.presetn  (presetn),
		.in_valid (f_out_valid && tx_en),
		.in_data  (f_out[7:0]),
		.in_last  (f_out[`DRTL_TX_LAST]),
		.in_ready (ft_ready),
		.txd      (link.ctl_up_txd),
		.de       (link.ctl_up_de)
	);

	// odometry line, receive only
	drtl_uart_rx u_odo_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.rxd     (link.odo_line),
		.rx_byte (ob),
		.rx_stb  (os),
		.rx_ferr (of),
		.rx_gap  (og)
	);

	drtl_frame_rx #(.FIXED_LEN(16'(`DRTL_ODO_VAR_BYTES))) u_odo_fr (
		.pclk     (pclk),
		.presetn  (presetn),
		.byte_stb (os),
		.in_byte  (ob),
		.gap      (og),
		.out_stb  (odo_stb),
		.out_byte (odo_byte),
		.out_idx  (odo_idx),
		.done     (odo_done),
		.crc_ok   (odo_ok)
	);

	// odometry bytes gathered, kept only from a good package
	for (genvar i = 0; i < `DRTL_ODO_VAR_BYTES; i++)
	begin : g_odo
		logic [7:0] rcv;
		logic [7:0] kept;
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				rcv <= '0;
				kept <= '0;
			end
			else
			begin
				if (odo_stb && odo_idx == 16'(i))
					rcv <= odo_byte;
				if (odo_done && odo_ok)
					kept <= rcv;
			end
		end
		assign odo_kept[127 - 8 * i -: 8] = kept;
	end

	// incoming control frames
	drtl_uart_rx u_ctl_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.rxd     (link.ctl_down_line),
		.rx_byte (cb),
		.rx_stb  (cs),
		.rx_ferr (cf),
		.rx_gap  (cg)
	);

	drtl_frame_rx #(.FIXED_LEN(16'h0000)) u_ctl_fr (
		.pclk     (pclk),
		.presetn  (presetn),
		.byte_stb (cs),
		.in_byte  (cb),
		.gap      (cg),
		.out_stb  (ctl_stb),
		.out_byte (ctl_byte),
		.out_idx  (ctl_idx),
		.done     (ctl_done),
		.crc_ok   (ctl_ok)
	);

	// last header, sequence and good frame count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_hdr <= '0;
			ctl_seq <= '0;
			ctl_frames <= '0;
		end
		else
		begin
			if (ctl_stb && ctl_idx == 16'h0000)
				ctl_hdr <= ctl_byte;
			if (ctl_stb && ctl_idx == 16'h0001)
				ctl_seq <= ctl_byte;
			if (ctl_done && ctl_ok)
				ctl_frames <= ctl_frames + 8'h01;
		end
	end
endmodule

// ### hw/drtl_host.sv
// test environment end: management control channel and odometry source
// assumes drtl_device.sv compiled first for the shared engines
`timescale 1ns/100ps
`include "drtl_params.svh"

module drtl_host #(
	parameter int ODO_PERIOD_CYCLES = `DRTL_ODO_PERIOD_CYC
) (
	input  logic                  pclk,
	input  logic                  presetn,
	drtl_link_if.host             link,
	input  logic                  odo_enable,
	input  drtl_pkg::drtl_word_t  odo_distance,
	input  drtl_pkg::drtl_word_t  odo_dist_err,
	input  logic [15:0]           odo_speed,
	input  drtl_pkg::drtl_word_t  odo_time,
	input  drtl_pkg::drtl_byte_t  odo_time_err,
	output logic                  odo_sent,
	input  logic                  ctl_tx_valid,
	input  drtl_pkg::drtl_byte_t  ctl_tx_data,
	input  logic                  ctl_tx_last,
	output logic                  ctl_tx_ready,
	output logic                  ctl_rx_valid,
	output drtl_pkg::drtl_byte_t  ctl_rx_byte,
	output logic [15:0]           ctl_rx_index,
	output logic                  ctl_rx_done,
	output logic                  ctl_rx_crc_ok,
	output logic                  ctl_rx_frame_err
);
	import drtl_pkg::*;
	logic [31:0]  tmr;
	logic         busy;
	logic [3:0]   idx;
	logic [7:0]   seq;
	logic [127:0] snap;
	logic         o_ready;
	logic         q_valid;
	drtl_txw_t    q_out;
	logic         c_ready;
	logic [7:0]   rb;
	logic         rs;
	logic         rg;

	// package timer, snapshot and byte walk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tmr <= '0;
			busy <= 1'b0;
			idx <= '0;
			seq <= '0;
			snap <= '0;
			odo_sent <= 1'b0;
		end
		else
		begin
			odo_sent <= 1'b0;
			if (tmr == 32'(ODO_PERIOD_CYCLES - 1))
				tmr <= '0;
			else
				tmr <= tmr + 32'h1;
			if (tmr == '0 && odo_enable && !busy)
			begin
				busy <= 1'b1;
				idx <= '0;
				snap <= {odo_distance, odo_dist_err, odo_speed,
					odo_time, odo_time_err, seq};
			end
			else if (busy && o_ready)
			begin
				idx <= idx + 4'h1;
				if (idx == 4'(`DRTL_ODO_VAR_BYTES - 1))
				begin
					busy <= 1'b0;
					odo_sent <= 1'b1;
					seq <= (seq == 8'(`DRTL_ODO_SEQ_MOD - 1)) ? '0 : seq + 8'h1;
				end
			end
		end
	end

	drtl_frame_tx u_odo_tx (
		.pclk     (pclk),
		.presetn  (presetn),
		.in_valid (busy),
		.in_data  (snap[127 - 8 * idx -: 8]),
		.in_last  (idx == 4'(`DRTL_ODO_VAR_BYTES - 1)),
		.in_ready (o_ready),
		.txd      (link.odo_txd),
		.de       (link.odo_de)
	);

	// control frames from the management side
	drtl_fifo #(.W(9), .D(`DRTL_FIFO_DEPTH)) u_txq (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (ctl_tx_valid),
		.in_data   ({ctl_tx_last, ctl_tx_data}),
		.in_ready  (ctl_tx_ready),
		.out_valid (q_valid),
		.out_ready (c_ready),
		.out_data  (q_out)
	);

	drtl_frame_tx u_ctl_tx (
		.pclk     (pclk),
		.presetn  (presetn),
		.in_valid (q_valid),
		.in_data  (q_out[7:0]),
		.in_last  (q_out[`DRTL_TX_LAST]),
		.in_ready (c_ready),
		.txd      (link.ctl_down_txd),
		.de       (link.ctl_down_de)
	);

	// status frames back from the adapter
	drtl_uart_rx u_ctl_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.rxd     (link.ctl_up_line),
		.rx_byte (rb),
		.rx_stb  (rs),
		.rx_ferr (ctl_rx_frame_err),
		.rx_gap  (rg)
	);

	drtl_frame_rx #(.FIXED_LEN(16'h0000)) u_ctl_fr (
		.pclk     (pclk),
		.presetn  (presetn),
		.byte_stb (rs),
		.in_byte  (rb),
		.gap      (rg),
		.out_stb  (ctl_rx_valid),
		.out_byte (ctl_rx_byte),
		.out_idx  (ctl_rx_index),
		.done     (ctl_rx_done),
		.crc_ok   (ctl_rx_crc_ok)
	);
endmodule

// ### tb/drtl_checker.sv
// line checks on the three rs485 pairs between the two link ends
// assumes the bench feeds it the interface signals and pclk
`timescale 1ns/100ps

module drtl_checker (
	input logic pclk,
	input logic presetn,
	input logic ctl_down_txd,
	input logic ctl_down_de,
	input logic ctl_up_txd,
	input logic ctl_up_de,
	input logic odo_txd,
	input logic odo_de
);
	logic [11:0] cnt;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// cycle index inside the current odometry character
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cnt <= 12'h000;
		else
			cnt <= odo_de ? cnt + 12'h001 : 12'h000;

	property p_odo_idle; !odo_de |-> odo_txd; endproperty
	a_odo_idle: assert property (p_odo_idle) else $error("odo idle low");
	property p_odo_start; odo_de && cnt < 12'h0ae |-> !odo_txd; endproperty
	a_odo_start: assert property (p_odo_start) else $error("odo start");
	property p_odo_stop; odo_de && cnt >= 12'h61e |-> odo_txd; endproperty
	a_odo_stop: assert property (p_odo_stop) else $error("odo stop");
	property p_odo_bit;
		odo_de && cnt % 12'h0ae != 12'h000 |-> $stable(odo_txd);
	endproperty
	a_odo_bit: assert property (p_odo_bit) else $error("odo bit");
	property p_odo_len; $fell(odo_de) |-> cnt == 12'h6cc; endproperty
	a_odo_len: assert property (p_odo_len) else $error("odo len");
	property p_dn_idle; !ctl_down_de |-> ctl_down_txd; endproperty
	a_dn_idle: assert property (p_dn_idle) else $error("down idle");
	property p_dn_start; $rose(ctl_down_de) |-> !ctl_down_txd; endproperty
	a_dn_start: assert property (p_dn_start) else $error("down start");
	property p_up_idle; !ctl_up_de |-> ctl_up_txd; endproperty
	a_up_idle: assert property (p_up_idle) else $error("up idle");
	property p_up_start; $rose(ctl_up_de) |-> !ctl_up_txd[*8]; endproperty
	a_up_start: assert property (p_up_start) else $error("up start");

	// main traffic seen
	c_odo: cover property ($fell(odo_de));
	c_dn: cover property ($fell(ctl_down_de));
	c_up: cover property ($fell(ctl_up_de));
endmodule

// ### tb/testbench.sv
// bench top: both link ends, the line checker and the scenarios
// assumes the hw sources are compiled first, header on include path
`timescale 1ns/100ps
`include "drtl_params.svh"

module testbench;
	import drtl_pkg::*;
	logic       pclk = 0;
	logic       presetn = 0;
	logic [7:0] paddr = 0;
	logic       psel = 0;
	logic       penable = 0;
	logic       pwrite = 0;
	drtl_word_t pwdata = 0;
	drtl_word_t prdata;
	logic       pready;
	logic       pslverr;
	logic       odo_enable = 1;
	drtl_word_t odo_distance = 32'h01234567;
	drtl_word_t odo_dist_err = 32'h89abcdef;
	logic [15:0] odo_speed = 16'hfedc;
	drtl_word_t odo_time = 32'h13579bdf;
	drtl_byte_t odo_time_err = 8'h5a;
	logic       ctl_tx_valid = 0;
	drtl_byte_t ctl_tx_data = 0;
	logic       ctl_tx_last = 0;
	logic       ctl_tx_ready;
	logic       ctl_rx_valid;
	drtl_byte_t ctl_rx_byte;
	logic [15:0] ctl_rx_index;
	logic       ctl_rx_done;
	logic       ctl_rx_crc_ok;
	logic       odo_sent;
	logic       ctl_rx_frame_err;
	int         n_sent = 0;
	int         n_ferr = 0;
	int         error_cnt = 0;
	int         n_tests = 0;
	// link status frame with its known crc
	drtl_byte_t fr [12] = '{8'h02, 8'h25, 8'h00, 8'h04, 8'h12, 8'h34,
		8'h56, 8'h78, 8'h08, 8'h03, 8'h42, 8'ha4};

	always #25 pclk = ~pclk;

	drtl_link_if link ();
	drtl_device drtl_device_inst (.pclk, .presetn, .link(link.device),
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr);
	drtl_host #(.ODO_PERIOD_CYCLES(36000)) drtl_host_inst (.pclk,
		.presetn, .link(link.host), .odo_enable, .odo_distance,
		.odo_dist_err, .odo_speed, .odo_time, .odo_time_err,
		.odo_sent, .ctl_tx_valid, .ctl_tx_data, .ctl_tx_last,
		.ctl_tx_ready, .ctl_rx_valid, .ctl_rx_byte, .ctl_rx_index,
		.ctl_rx_done, .ctl_rx_crc_ok, .ctl_rx_frame_err);
	drtl_checker chk_inst (.pclk, .presetn,
		.ctl_down_txd(link.ctl_down_txd), .ctl_down_de(link.ctl_down_de),
		.ctl_up_txd(link.ctl_up_txd), .ctl_up_de(link.ctl_up_de),
		.odo_txd(link.odo_txd), .odo_de(link.odo_de));

	// count host pulses for later checks
	always @(posedge pclk)
	begin
		if (odo_sent === 1'b1)
			n_sent++;
		if (ctl_rx_frame_err === 1'b1)
			n_ferr++;
	end

	task automatic report_and_stop;
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("ERROR %0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// a wait that ran out
	task automatic to_fail;
		chk(32'h0, 32'h1);
		report_and_stop;
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input drtl_word_t d, output drtl_word_t r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 2000);
		if (n == 2000)
			to_fail;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// read a register until a masked bit shows
	task automatic poll(input logic [7:0] a, input drtl_word_t m,
		output drtl_word_t r);
		int n;
		logic e;
		n = 0;
		do
		begin
			apb(1'b0, a, 32'h0, r, e);
			n++;
		end
		while ((r & m) == 32'h0 && n < 20000);
		if (n == 20000)
			to_fail;
	endtask

	// quiet status, unmapped access
	task automatic t_regs;
		drtl_word_t r;
		logic e;
		apb(1'b0, `DRTL_REG_STATUS, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
	endtask

	// first odometry package lands in the registers
	task automatic t_odo;
		drtl_word_t r;
		logic e;
		logic [7:0] ad [5] = '{`DRTL_REG_ODO_DIST, `DRTL_REG_ODO_DERR,
			`DRTL_REG_ODO_SPEED, `DRTL_REG_ODO_TIME, `DRTL_REG_ODO_MISC};
		drtl_word_t ex [5] = '{32'h01234567, 32'h89abcdef, 32'h0000fedc,
			32'h13579bdf, 32'h00005a00};
		poll(`DRTL_REG_STATUS, 32'h8, r);
		chk(n_sent, 32'h1);
		chk(r[2:0], 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, ad[i], 32'h0, r, e);
			chk(r, ex[i]);
		end
		apb(1'b1, `DRTL_REG_STATUS, 32'h8, r, e);
		apb(1'b0, `DRTL_REG_STATUS, 32'h0, r, e);
		chk(r[3], 32'h0);
	endtask

	// host frames a variable, device checks it
	task automatic t_down;
		drtl_word_t r;
		logic e;
		int n;
		@(posedge pclk);
		for (int i = 0; i < 8; i++)
		begin
			ctl_tx_valid <= 1'b1;
			ctl_tx_data <= fr[i];
			ctl_tx_last <= i == 7;
			n = 0;
			do
			begin
				@(posedge pclk);
				n++;
			end
			while (ctl_tx_ready !== 1'b1 && n < 99);
			if (n == 99)
				to_fail;
		end
		ctl_tx_valid <= 1'b0;
		poll(`DRTL_REG_CTL_INFO, 32'h00ff0000, r);
		chk(r, 32'h00010225);
		poll(`DRTL_REG_CTRL, 32'h1, r);
		apb(1'b0, `DRTL_REG_STATUS, 32'h0, r, e);
		chk(r & 32'h7, 32'h0);
	endtask

	// device sends the same frame, host sees crc bytes
	task automatic t_up;
		drtl_word_t r;
		logic e;
		int n;
		int k;
		for (int i = 0; i < 8; i++)
			apb(1'b1, `DRTL_REG_TXDATA, {23'h0, i == 7, fr[i]}, r, e);
		k = 0;
		n = 0;
		while (ctl_rx_done !== 1'b1 && n < 30000)
		begin
			@(posedge pclk);
			n++;
			if (ctl_rx_valid === 1'b1)
			begin
				chk(ctl_rx_index, k);
				chk(ctl_rx_byte, fr[k]);
				k++;
			end
		end
		if (n == 30000)
			to_fail;
		@(posedge pclk);
		chk(k, 12);
		chk(ctl_rx_crc_ok, 32'h1);
		chk(n_ferr, 32'h0);
	endtask

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_odo;
		t_down;
		t_up;
		report_and_stop;
	end
endmodule
